// >>> hsc_defines.svh
/*
  Offsets, field positions, reset values and timing figures of one
  high-speed counter channel. Assumes a 40 MHz register clock.
*/
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

`define CLK_MHZ        40
// register byte offsets
`define REG_CTRL       8'h00
`define REG_FILT       8'h04
`define REG_UPPER      8'h08
`define REG_LOWER      8'h0C
`define REG_INIT       8'h10
`define REG_PRESET     8'h14
`define REG_STATUS     8'h18
`define REG_COUNT      8'h1C
// control fields
`define CTL_PREP       0
`define CTL_CNTEN      1
`define CTL_REV        2
`define CTL_RING       3
`define CTL_OVFEN      4
`define CTL_INTSRC     5
`define CTL_TSEL       6
`define CTL_DEC        8
`define CTL_MUL        10
// filter fields
`define FLT_AB         0
`define FLT_Z          4
`define FLT_CT         8
// status fields
`define ST_DONE        0
`define ST_OVF         1
`define ST_UDF         2
`define ST_PINS        3
// reset values
`define CTRL_RST       32'h0000_0000
`define UPPER_RST      32'h7FFF_FFFF
`define LOWER_RST      32'h8000_0000
`define SMAX           32'h7FFF_FFFF
`define SMIN           32'h8000_0000
// internal clock tick periods, ns
`define TICK0_NS       250
`define TICK1_NS       1000
`define TICK2_NS       10000
`define TICK3_NS       100000
// pin filter time constants, ns
`define TF_01_NS       100
`define TF_02_NS       200
`define TF_05_NS       500
`define TF_1_NS        1000
`define TF_2_NS        2000
`define TF_5_NS        5000
`define TF_10_NS       10000
`define TF_20_NS       20000
`define TF_50_NS       50000
`define TF_100_NS      100000
`define TF_500_NS      500000
`define TF_1M_NS       1000000
`define TF_2M_NS       2000000
`define TF_5M_NS       5000000
`define TF_10M_NS      10000000

`endif

// >>> hsc_pkg.sv
/*
  Types shared by the counter channel files.
  Assumes hsc_defines.svh is compiled alongside.
*/
package hsc_pkg;
  // preparation sequence, gray along idle -> check -> ready
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_READY = 2'b11
  } prep_state_t;

  typedef enum logic [1:0]
  {
    DEC_QUAD = 2'b00,
    DEC_UPDN = 2'b01,
    DEC_PDIR = 2'b10
  } dec_mode_t;
endpackage

// >>> pin_filter.sv
/*
  Two-flop synchroniser and digital noise filter for one pin.
  Assumes thr is a stable run-time setting from the register clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_filter #(
  parameter int W = 19
)(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         pin_in,
  input  wire logic [W-1:0] thr,
  output var  logic         q_r
);
  logic         s1_r;
  logic         s2_r;
  logic [W-1:0] run_r;

  // double-flop synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
    end
  end

  // new level must stand thr cycles before it passes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_r <= '0;
      q_r   <= 1'b0;
    end
    else if (s2_r == q_r)
      run_r <= '0;
    else if (run_r + W'(1) >= thr)
    begin
      q_r   <= s2_r;
      run_r <= '0;
    end
    else
      run_r <= run_r + W'(1);
  end

  property p_filt_follow;
    @(posedge aclk) disable iff (!aresetn)
    $changed(q_r) |-> $past(s2_r) == q_r && $past(run_r) + W'(1) >= thr;
  endproperty
  a_filt_follow: assert property (p_filt_follow)
    else $error("filter output moved without a stable input");
endmodule

`default_nettype wire

// >>> hs_counter_chan.sv
/*
  One 32-bit high-speed counter channel with AXI4-Lite registers.
  Assumes quadrature or pulse pins asynchronous to aclk (40 MHz).
*/
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.svh"

module hs_counter_chan
  import hsc_pkg::*;
#(
  parameter int FLT_W   = 19,
  parameter int C500U   = (`TF_500_NS * `CLK_MHZ + 999) / 1000,
  parameter int C1M     = (`TF_1M_NS * `CLK_MHZ + 999) / 1000,
  parameter int C2M     = (`TF_2M_NS * `CLK_MHZ + 999) / 1000,
  parameter int C5M     = (`TF_5M_NS * `CLK_MHZ + 999) / 1000,
  parameter int C10M    = (`TF_10M_NS * `CLK_MHZ + 999) / 1000
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  input  wire logic        in_a,
  input  wire logic        in_b,
  input  wire logic        in_z,
  input  wire logic        in_c0,
  input  wire logic        in_c1,
  output var  logic        chan0_prep_done,
  output var  logic [31:0] count_r
);
  if (FLT_W < 19 || C10M >= (1 << FLT_W))
  begin : g_chk
    $error("FLT_W too narrow for the filter times");
  end

  localparam int TK0 = `TICK0_NS * `CLK_MHZ / 1000;
  localparam int TK1 = `TICK1_NS * `CLK_MHZ / 1000;
  localparam int TK2 = `TICK2_NS * `CLK_MHZ / 1000;
  localparam int TK3 = `TICK3_NS * `CLK_MHZ / 1000;

  logic [31:0] ctrl_r, filt_r, upper_r, lower_r, init_r, preset_r;
  logic [7:0]  awa_r;
  logic        aw_got_r, w_got_r, ovf_r, udf_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  prep_state_t st_r, st_nxt;
  logic        a_f, b_f, z_f, c0_f, c1_f, a_d_r, b_d_r;
  logic        ev, dec_up, up_eff, tick, step, cfg_ok, wr_go, prep_req;
  logic [11:0] pre_r;
  logic [31:0] cnt_nxt;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    for (int i = 0; i < 4; i++)
      if (s[i]) old[8*i +: 8] = d[8*i +: 8];
    return old;
  endfunction

  // signed window check
  function automatic logic inside_lim(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
    return $signed(v) >= $signed(lo) && $signed(v) <= $signed(hi);
  endfunction

  // fast pin filter selection, shared by A/B and Z
  function automatic logic [FLT_W-1:0] fast_cyc(input logic [2:0] s);
    case (s)
      3'h1:    fast_cyc = FLT_W'((`TF_01_NS * `CLK_MHZ + 999) / 1000);
      3'h2:    fast_cyc = FLT_W'((`TF_02_NS * `CLK_MHZ + 999) / 1000);
      3'h3:    fast_cyc = FLT_W'((`TF_05_NS * `CLK_MHZ + 999) / 1000);
      3'h4:    fast_cyc = FLT_W'((`TF_1_NS * `CLK_MHZ + 999) / 1000);
      3'h5:    fast_cyc = FLT_W'((`TF_2_NS * `CLK_MHZ + 999) / 1000);
      3'h6:    fast_cyc = FLT_W'((`TF_10_NS * `CLK_MHZ + 999) / 1000);
      default: fast_cyc = '0;
    endcase
  endfunction

  // control pin filter selection, shared by both control inputs
  function automatic logic [FLT_W-1:0] ctl_cyc(input logic [3:0] s);
    case (s)
      4'h1:    ctl_cyc = FLT_W'((`TF_2_NS * `CLK_MHZ + 999) / 1000);
      4'h2:    ctl_cyc = FLT_W'((`TF_5_NS * `CLK_MHZ + 999) / 1000);
      4'h3:    ctl_cyc = FLT_W'((`TF_10_NS * `CLK_MHZ + 999) / 1000);
      4'h4:    ctl_cyc = FLT_W'((`TF_20_NS * `CLK_MHZ + 999) / 1000);
      4'h5:    ctl_cyc = FLT_W'((`TF_50_NS * `CLK_MHZ + 999) / 1000);
      4'h6:    ctl_cyc = FLT_W'((`TF_100_NS * `CLK_MHZ + 999) / 1000);
      4'h7:    ctl_cyc = FLT_W'(C500U);
      4'h8:    ctl_cyc = FLT_W'(C1M);
      4'h9:    ctl_cyc = FLT_W'(C2M);
      4'hA:    ctl_cyc = FLT_W'(C5M);
      4'hB:    ctl_cyc = FLT_W'(C10M);
      default: ctl_cyc = '0;
    endcase
  endfunction

  pin_filter #(.W(FLT_W)) u_fa (.aclk(aclk), .aresetn(aresetn), .pin_in(in_a),
    .thr(fast_cyc(filt_r[`FLT_AB +: 3])), .q_r(a_f));
  pin_filter #(.W(FLT_W)) u_fb (.aclk(aclk), .aresetn(aresetn), .pin_in(in_b),
    .thr(fast_cyc(filt_r[`FLT_AB +: 3])), .q_r(b_f));
  pin_filter #(.W(FLT_W)) u_fz (.aclk(aclk), .aresetn(aresetn), .pin_in(in_z),
    .thr(fast_cyc(filt_r[`FLT_Z +: 3])), .q_r(z_f));
  pin_filter #(.W(FLT_W)) u_f0 (.aclk(aclk), .aresetn(aresetn), .pin_in(in_c0),
    .thr(ctl_cyc(filt_r[`FLT_CT +: 4])), .q_r(c0_f));
  pin_filter #(.W(FLT_W)) u_f1 (.aclk(aclk), .aresetn(aresetn), .pin_in(in_c1),
    .thr(ctl_cyc(filt_r[`FLT_CT +: 4])), .q_r(c1_f));

  // write channel: address and data taken in either order
  assign awready = !aw_got_r && !bvalid;
  assign wready  = !w_got_r && !bvalid;
  assign wr_go   = aw_got_r && w_got_r && !bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r    <= 8'h00;
      wd_r     <= 32'h0000_0000;
      ws_r     <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= 2'b00;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        awa_r    <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wd_r    <= wdata;
        ws_r    <= wstrb;
      end
      if (wr_go)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (awa_r[1:0] != 2'b00 || awa_r > `REG_COUNT) ? 2'b11 : 2'b00;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r   <= `CTRL_RST;
      filt_r   <= 32'h0000_0000;
      upper_r  <= `UPPER_RST;
      lower_r  <= `LOWER_RST;
      init_r   <= 32'h0000_0000;
      preset_r <= 32'h0000_0000;
    end
    else if (wr_go)
    begin
      case (awa_r)
        `REG_CTRL:   ctrl_r   <= merge(ctrl_r, wd_r, ws_r) & 32'h0000_0FFF;
        `REG_FILT:   filt_r   <= merge(filt_r, wd_r, ws_r) & 32'h0000_0F77;
        `REG_UPPER:  upper_r  <= merge(upper_r, wd_r, ws_r);
        `REG_LOWER:  lower_r  <= merge(lower_r, wd_r, ws_r);
        `REG_INIT:   init_r   <= merge(init_r, wd_r, ws_r);
        `REG_PRESET: preset_r <= merge(preset_r, wd_r, ws_r);
        default:     ;
      endcase
    end
  end

  // read channel, one cycle to answer
  assign arready = !rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp  <= 2'b00;
      case (araddr)
        `REG_CTRL:   rdata <= ctrl_r;
        `REG_FILT:   rdata <= filt_r;
        `REG_UPPER:  rdata <= upper_r;
        `REG_LOWER:  rdata <= lower_r;
        `REG_INIT:   rdata <= init_r;
        `REG_PRESET: rdata <= preset_r;
        `REG_STATUS: rdata <= {24'h00_0000, c1_f, c0_f, z_f, b_f, a_f,
                               udf_r, ovf_r, chan0_prep_done};
        `REG_COUNT:  rdata <= count_r;
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= 2'b11;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // limits and start values must be legal
  assign cfg_ok = upper_r != `SMIN && lower_r != `SMAX &&
                  $signed(upper_r) > $signed(lower_r) &&
                  inside_lim(init_r, lower_r, upper_r) &&
                  inside_lim(preset_r, lower_r, upper_r);

  // request is a level; dropping it stops the channel
  assign prep_req = ctrl_r[`CTL_PREP];
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:  if (prep_req) st_nxt = ST_CHECK;
      ST_CHECK: if (!prep_req) st_nxt = ST_IDLE;
                else if (cfg_ok) st_nxt = ST_READY;
      ST_READY: if (!prep_req) st_nxt = ST_IDLE;
                else if (!cfg_ok) st_nxt = ST_CHECK;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r            <= ST_IDLE;
      chan0_prep_done <= 1'b0;
    end
    else
    begin
      st_r            <= st_nxt;
      chan0_prep_done <= st_nxt == ST_READY;
    end
  end

  // edge decoding per method and factor
  always_comb
  begin
    ev     = 1'b0;
    dec_up = 1'b1;
    case (dec_mode_t'(ctrl_r[`CTL_DEC +: 2]))
      DEC_QUAD:
      begin
        if (a_f != a_d_r &&
            (ctrl_r[`CTL_MUL +: 2] != 2'b00 || (a_f && !b_f) || (a_f && b_f)))
        begin
          ev     = ctrl_r[`CTL_MUL +: 2] != 2'b00 || a_f;
          dec_up = a_f ^ b_f;
        end
        else if (b_f != b_d_r && ctrl_r[`CTL_MUL +: 2] == 2'b10)
        begin
          ev     = 1'b1;
          dec_up = a_f == b_f;
        end
      end
      DEC_UPDN:
      begin
        ev     = (a_f != a_d_r || b_f != b_d_r) &&
                 (ctrl_r[`CTL_MUL +: 2] != 2'b00 || (a_f && !a_d_r) ||
                  (b_f && !b_d_r));
        dec_up = a_f != a_d_r;
      end
      DEC_PDIR:
      begin
        ev     = a_f != a_d_r && (ctrl_r[`CTL_MUL +: 2] != 2'b00 || a_f);
        dec_up = !b_f;
      end
      default: ;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_r <= 12'h000;
    else if (tick)
      pre_r <= 12'h000;
    else
      pre_r <= pre_r + 12'h001;
  end
  always_comb
  begin
    case (ctrl_r[`CTL_TSEL +: 2])
      2'b00:   tick = pre_r == 12'(TK0 - 1);
      2'b01:   tick = pre_r == 12'(TK1 - 1);
      2'b10:   tick = pre_r == 12'(TK2 - 1);
      default: tick = pre_r == 12'(TK3 - 1);
    endcase
  end

  assign step   = chan0_prep_done && ctrl_r[`CTL_CNTEN] &&
                  (ctrl_r[`CTL_INTSRC] ? tick : ev);
  assign up_eff = (ctrl_r[`CTL_INTSRC] ? 1'b1 : dec_up) ^ ctrl_r[`CTL_REV];

  always_comb
  begin
    cnt_nxt = count_r;
    if (st_r != ST_READY && st_nxt == ST_READY)
      cnt_nxt = init_r;
    else if (step && ctrl_r[`CTL_RING])
      cnt_nxt = up_eff ? (count_r == upper_r ? lower_r : count_r + 32'h1)
                       : (count_r == lower_r ? upper_r : count_r - 32'h1);
    else if (step && ctrl_r[`CTL_OVFEN])
    begin
      if (up_eff && $signed(count_r) < $signed(upper_r))
        cnt_nxt = count_r + 32'h1;
      else if (!up_eff && $signed(count_r) > $signed(lower_r))
        cnt_nxt = count_r - 32'h1;
    end
    else if (step)
      cnt_nxt = up_eff ? count_r + 32'h1 : count_r - 32'h1;
  end

  // count and sticky limit flags, set beats write-one-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_r <= 32'h0000_0000;
      a_d_r   <= 1'b0;
      b_d_r   <= 1'b0;
      ovf_r   <= 1'b0;
      udf_r   <= 1'b0;
    end
    else
    begin
      count_r <= cnt_nxt;
      a_d_r   <= a_f;
      b_d_r   <= b_f;
      if (step && !ctrl_r[`CTL_RING] && ctrl_r[`CTL_OVFEN] && up_eff &&
          $signed(count_r) >= $signed(upper_r))
        ovf_r <= 1'b1;
      else if (wr_go && awa_r == `REG_STATUS && ws_r[0] && wd_r[`ST_OVF])
        ovf_r <= 1'b0;
      if (step && !ctrl_r[`CTL_RING] && ctrl_r[`CTL_OVFEN] && !up_eff &&
          $signed(count_r) <= $signed(lower_r))
        udf_r <= 1'b1;
      else if (wr_go && awa_r == `REG_STATUS && ws_r[0] && wd_r[`ST_UDF])
        udf_r <= 1'b0;
    end
  end

  property p_done_needs_cfg;
    @(posedge aclk) disable iff (!aresetn)
    chan0_prep_done |-> $past(prep_req) && $past(cfg_ok);
  endproperty
  a_done_needs_cfg: assert property (p_done_needs_cfg)
    else $error("ready status without valid configuration");

  property p_done_rises;
    @(posedge aclk) disable iff (!aresetn)
    st_r == ST_CHECK && prep_req && cfg_ok |=> chan0_prep_done && count_r == $past(init_r);
  endproperty
  a_done_rises: assert property (p_done_rises)
    else $error("ready status did not rise with initial count");

  property p_idle_hold;
    @(posedge aclk) disable iff (!aresetn)
    !chan0_prep_done && st_nxt != ST_READY ##1 st_r != ST_READY |-> $stable(count_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("count moved while not ready");

  property p_ring_up;
    @(posedge aclk) disable iff (!aresetn)
    step && ctrl_r[`CTL_RING] && up_eff && count_r == upper_r |=> count_r == $past(lower_r);
  endproperty
  a_ring_up: assert property (p_ring_up)
    else $error("ring increment at upper did not wrap");

  property p_ring_dn;
    @(posedge aclk) disable iff (!aresetn)
    step && ctrl_r[`CTL_RING] && !up_eff && count_r == lower_r |=> count_r == $past(upper_r);
  endproperty
  a_ring_dn: assert property (p_ring_dn)
    else $error("ring decrement at lower did not wrap");

  property p_lin_stop;
    @(posedge aclk) disable iff (!aresetn)
    step && !ctrl_r[`CTL_RING] && ctrl_r[`CTL_OVFEN] && up_eff && count_r == upper_r
      |=> $stable(count_r) && ovf_r;
  endproperty
  a_lin_stop: assert property (p_lin_stop)
    else $error("checked linear count passed upper limit");

  property p_lin_free;
    @(posedge aclk) disable iff (!aresetn)
    step && !ctrl_r[`CTL_RING] && !ctrl_r[`CTL_OVFEN] && up_eff && st_r == ST_READY
      && st_nxt == ST_READY |=> count_r == $past(count_r) + 32'h1;
  endproperty
  a_lin_free: assert property (p_lin_free)
    else $error("unchecked linear count did not advance");

  property p_rev;
    @(posedge aclk) disable iff (!aresetn)
    step && ctrl_r[`CTL_REV] && !ctrl_r[`CTL_INTSRC] && !dec_up && !ctrl_r[`CTL_RING]
      && !ctrl_r[`CTL_OVFEN] && st_nxt == ST_READY |=> count_r == $past(count_r) + 32'h1;
  endproperty
  a_rev: assert property (p_rev)
    else $error("reversed count went the wrong way");

  property p_tick_gap;
    @(posedge aclk) disable iff (!aresetn)
    tick && ctrl_r[`CTL_TSEL +: 2] == 2'b00
      ##1 ctrl_r[`CTL_TSEL +: 2] == 2'b00 [*8]
      ##1 ctrl_r[`CTL_TSEL +: 2] == 2'b00 |-> !tick ##1 tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("fastest tick not every ten cycles");
endmodule

`default_nettype wire

// >>> enc_model.sv
/*
  Quadrature pulse source standing in for an encoder.
  Assumes go is a one-cycle request from the bench, dir held with it.
*/
`timescale 1ns/1ps
`default_nettype none

module enc_model
(
  input  wire logic aclk,
  input  wire logic go,
  input  wire logic dir,
  output var  logic a,
  output var  logic b,
  output var  logic busy
);
  logic [3:0] t_r = 4'h0;
  logic       dn_r = 1'b0;
  logic [1:0] ph;

  // one full gray cycle per step, four clocks per phase
  always_ff @(posedge aclk)
  begin
    if (go && !busy)
      dn_r <= dir;
    if (go || busy)
      t_r <= t_r + 4'h1;
  end

  always_comb
  begin
    busy = t_r != 4'h0;
    ph = t_r[3:2];
    a = dn_r ? ph[1] : ph[0] ^ ph[1];
    b = dn_r ? ph[0] ^ ph[1] : ph[1];
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for one counter channel.
  Assumes enc_model on phases A and B; Z and control pins set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defines.svh"

module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, go = 1'b0, dir = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd, c0;
  logic [1:0]  rs;
  logic [3:0]  ws = 4'hF;
  logic        pz = 1'b0, pc0 = 1'b0, pc1 = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   done, in_a, in_b, busy;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata, count_r;
  int          num_errors = 0;
  int          n_checks = 0;
  int          per[4] = '{10, 40, 400, 4000};

  always #12.5 aclk = ~aclk;

  hs_counter_chan #(.C500U(50), .C1M(60), .C2M(70), .C5M(80), .C10M(90))
  i_dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(ws),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .in_a(in_a), .in_b(in_b), .in_z(pz), .in_c0(pc0), .in_c1(pc1),
    .chan0_prep_done(done), .count_r(count_r)
  );

  enc_model i_enc
  (
    .aclk(aclk), .go(go), .dir(dir), .a(in_a), .b(in_b), .busy(busy)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // write one word, hold each channel until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb)
      begin
        bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    num_errors++;
    complete_run();
  endtask

  // read one word into rd and rs
  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr)
      begin
        rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    num_errors++;
    complete_run();
  endtask

  // one encoder step, then let the pin pipeline settle
  task automatic step(input logic d);
    int i;
    go <= 1'b1;
    dir <= d;
    @(posedge aclk);
    go <= 1'b0;
    for (i = 0; i < 40; i++)
    begin
      @(negedge aclk);
      if (busy === 1'b0) break;
    end
    if (i == 40)
    begin
      num_errors++;
      complete_run();
    end
    repeat (8) @(posedge aclk);
  endtask

  // stop drops the request, start sets it held
  task automatic cfg(input logic [31:0] up, lo, ini, ctl);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_UPPER, up);
    wr(`REG_LOWER, lo);
    wr(`REG_INIT, ini);
    wr(`REG_PRESET, ini);
    wr(`REG_CTRL, ctl);
    repeat (4) @(posedge aclk);
  endtask

  task automatic t_regs();
    chk("done idle", done, 0);
    rd_reg(`REG_UPPER);
    chk("upper", rd, `UPPER_RST);
    rd_reg(`REG_LOWER);
    chk("lower", rd, `LOWER_RST);
    rd_reg(8'h20);
    chk("rresp", rs, 2'b11);
    wr(8'h20, 32'h1);
    chk("bresp", rs, 2'b11);
    $display("test regs ends");
  endtask

  task automatic t_prep();
    cfg(`SMAX, `SMIN, 32'h5, 32'h3);
    chk("done", done, 1);
    chk("init", count_r, 32'h5);
    step(0);
    chk("up", count_r, 32'h6);
    step(1);
    chk("down", count_r, 32'h5);
    cfg(32'h32, `SMIN, 32'h64, 32'h3);
    chk("bad init", done, 0);
    $display("test prep ends");
  endtask

  task automatic t_ring();
    cfg(32'h2, 32'hFFFF_FFFE, 32'h2, 32'hB);
    step(0);
    chk("ring up", count_r, 32'hFFFF_FFFE);
    step(1);
    chk("ring dn", count_r, 32'h2);
    step(1);
    chk("ring dn2", count_r, 32'h1);
    $display("test ring ends");
  endtask

  task automatic t_mode();
    cfg(`SMAX, `SMIN, 32'h0, 32'h7);
    step(0);
    chk("reverse", count_r, 32'hFFFF_FFFF);
    cfg(`SMAX, `SMIN, 32'h0, 32'h803);
    step(0);
    chk("x4", count_r, 32'h4);
    wr(`REG_FILT, 32'h6);
    step(0);
    chk("filtered", count_r, 32'h4);
    wr(`REG_FILT, 32'h0);
    cfg(2, `SMIN, 32'h2, 32'h13);
    step(0);
    chk("stop", count_r, 32'h2);
    rd_reg(`REG_STATUS);
    chk("ovf", rd, 32'h3);
    cfg(`SMAX, `SMIN, `SMAX, 32'h3);
    step(0);
    chk("wrap", count_r, `SMIN);
    $display("test modes ends");
  endtask

  task automatic t_dec();
    cfg(`SMAX, `SMIN, 32'h0, 32'h103);
    step(0);
    chk("up/down", count_r, 32'h0);
    cfg(`SMAX, `SMIN, 32'h0, 32'h203);
    step(1);
    chk("pulse dir", count_r, 32'hFFFF_FFFF);
    cfg(`SMAX, `SMIN, 32'h0, 32'h403);
    step(0);
    chk("x2", count_r, 32'h2);
    cfg(`SMAX, 32'h5, 32'h5, 32'h13);
    step(1);
    chk("stop low", count_r, 32'h5);
    $display("test decode ends");
  endtask

  task automatic t_pins();
    wr(`REG_FILT, 32'h0000_0100);
    ws <= 4'h1;
    wr(`REG_FILT, 32'hFFFF_FF00);
    ws <= 4'hF;
    rd_reg(`REG_FILT);
    chk("filter lanes", rd, 32'h0000_0100);
    pz  <= 1'b1;
    pc0 <= 1'b1;
    repeat (10) @(posedge aclk);
    rd_reg(`REG_STATUS);
    chk("pins early", rd, 32'h27);
    repeat (100) @(posedge aclk);
    rd_reg(`REG_STATUS);
    chk("pins late", rd, 32'h67);
    pz  <= 1'b0;
    pc1 <= 1'b1;
    wr(`REG_STATUS, 32'h6);
    repeat (100) @(posedge aclk);
    rd_reg(`REG_STATUS);
    chk("flags cleared", rd, 32'hC1);
    $display("test pins ends");
  endtask

  task automatic t_tick();
    for (int k = 0; k < 4; k++)
    begin
      cfg(`SMAX, `SMIN, 32'h0, 32'h23 | (k << 6));
      c0 = count_r;
      repeat (3 * per[k]) @(posedge aclk);
      c0 = count_r - c0;
      chk("ticks", c0 >= 2 && c0 <= 4, 1);
    end
    $display("test ticks ends");
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_prep();
    t_ring();
    t_mode();
    t_dec();
    t_pins();
    t_tick();
    complete_run();
  end
endmodule

`default_nettype wire
